// ===== qpi_cmd_defines.svh
// Opcodes, field positions, counts and reset values of the command decoder
`ifndef QPI_CMD_DEFINES_SVH
`define QPI_CMD_DEFINES_SVH
// ----------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------
`define OP_FAST_READ     8'h0b
`define OP_WRAP_READ     8'h0c
`define OP_QUAD_READ     8'heb
`define OP_PAGE_FILL     8'h02
`define OP_QUAD_FILL     8'h32
`define OP_SMALL_CLR     8'h20
`define OP_MID_CLR       8'h52
`define OP_LARGE_CLR     8'hd8
`define OP_CHIP_CLR_A    8'h60
`define OP_CHIP_CLR_B    8'hc7
`define OP_PAUSE         8'h75
`define OP_CONTINUE      8'h7a
`define OP_WRITE_ARM     8'h06
`define OP_WRITE_DISARM  8'h04
`define OP_VOL_ARM       8'h50
`define OP_STAT_RD       8'h05
`define OP_STAT_UP_RD    8'h35
`define OP_STAT_WR       8'h01
`define OP_STAT_UP_WR    8'h31
`define OP_PARAM_SET     8'hc0
`define OP_ID_READ       8'h9f
`define OP_QPI_EXIT      8'hff
`define OP_QPI_ENTER     8'h38
`define OP_RST_ARM       8'h66
`define OP_RST           8'h99
`define OP_SEC_PROG      8'h42
`define OP_SEC_CLR       8'h44
// ----------------------------------------------------------------------
// Phase counts
// ----------------------------------------------------------------------
`define OPC_LAST_NIB     4'h1
`define SPI_LAST_BIT     4'h7
`define ADDR_LAST_NIB    4'h5
`define STAT_WR_MAX      9'h002
`define ONE_BYTE_MAX     9'h001
`define ID_LAST_IDX      2'h3
// ----------------------------------------------------------------------
// Read parameter byte
// ----------------------------------------------------------------------
`define PARAM_RST        8'h00
`define DUMMY_SEL_HI     5
`define DUMMY_SEL_LO     4
`define WRAP_SEL_HI      1
`define WRAP_SEL_LO      0
`define DUMMY_SEL0       4'ha
`define DUMMY_SEL1       4'h4
`define DUMMY_SEL2       4'h6
`define DUMMY_SEL3       4'h8
`define WRAP_BASE        8'h08
// ----------------------------------------------------------------------
// Security area address fields and status latch bit
// ----------------------------------------------------------------------
`define SEC_TOP_ZERO     8'h00
`define SEC_MID_ZERO     3'h0
`define SEC_AREA_FIRST   4'h1
`define SEC_AREA_LAST    4'h3
`define WEL_BIT          1
`endif

// ===== qpi_cmd_pkg.sv
// Types shared by the command decoder
package qpi_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY,
    ST_DIN, ST_DOUT, ST_WAIT, ST_IGNORE
  } st_t;
endpackage : qpi_cmd_pkg

// ===== pin_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;

  // Each lane gets its own pair; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_q[g] <= 1'b1;
          q_o[g]    <= 1'b1;
        end else begin
          meta_q[g] <= d_i[g];
          q_o[g]    <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule : pin_sync

// ===== byte_store.sv
// Small page buffer with registered read data
`timescale 1ns/10ps
module byte_store #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // Read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule : byte_store

// ===== qpi_command_write_latch.sv
// QPI command decoder with write-enable latch and page buffer
`timescale 1ns/10ps
`include "qpi_cmd_defines.svh"
module qpi_command_write_latch import qpi_cmd_pkg::*; #(
  parameter int          PAGE_AW = 8,
  parameter logic [7:0]  MFR_ID  = 8'h5a,   // Arbitrary value
  parameter logic [15:0] DEV_ID  = 16'h1234 // Arbitrary value
) (
  // Clock and reset
  input  wire logic        SYS_CLK_I,
  input  wire logic        SRST_I,
  // Flash pins
  input  wire logic        SCLK_I,
  input  wire logic        CS_N_I,
  input  wire logic [3:0]  IO_I,
  output logic      [3:0]  IO_O,
  output logic      [3:0]  IO_OE_O,
  // Operation report
  output logic             OP_VALID_O,
  output logic      [7:0]  OP_CODE_O,
  output logic      [23:0] OP_ADDR_O,
  output logic      [8:0]  OP_NBYTES_O,
  output logic      [1:0]  SEC_AREA_O,
  // Status write report
  output logic      [7:0]  STAT_LO_O,
  output logic      [7:0]  STAT_HI_O,
  output logic             STAT_HI_VALID_O,
  output logic             STAT_VOLATILE_O,
  // Mode and configuration
  output logic             WEL_O,
  output logic             QPI_MODE_O,
  output logic      [3:0]  DUMMY_CLKS_O,
  output logic      [1:0]  WRAP_SEL_O
);
  // ----------------------------------------------------------------------
  // Opcode classes
  // ----------------------------------------------------------------------
  function automatic logic needs_wel(input logic [7:0] op);
    needs_wel = (op == `OP_PAGE_FILL)  || (op == `OP_QUAD_FILL)  ||
                (op == `OP_SMALL_CLR)  || (op == `OP_MID_CLR)    ||
                (op == `OP_LARGE_CLR)  || (op == `OP_CHIP_CLR_A) ||
                (op == `OP_CHIP_CLR_B) || (op == `OP_STAT_WR)    ||
                (op == `OP_STAT_UP_WR) || (op == `OP_SEC_PROG)   ||
                (op == `OP_SEC_CLR);
  endfunction : needs_wel

  function automatic logic is_read(input logic [7:0] op);
    is_read = (op == `OP_FAST_READ) || (op == `OP_WRAP_READ) ||
              (op == `OP_QUAD_READ);
  endfunction : is_read

  function automatic logic is_prog(input logic [7:0] op);
    is_prog = (op == `OP_PAGE_FILL) || (op == `OP_QUAD_FILL) ||
              (op == `OP_SEC_PROG);
  endfunction : is_prog

  function automatic logic has_addr(input logic [7:0] op);
    has_addr = is_read(op) || is_prog(op) || (op == `OP_SMALL_CLR) ||
               (op == `OP_MID_CLR) || (op == `OP_LARGE_CLR) ||
               (op == `OP_SEC_CLR);
  endfunction : has_addr

  function automatic logic has_data(input logic [7:0] op);
    has_data = is_prog(op) || (op == `OP_STAT_WR) ||
               (op == `OP_STAT_UP_WR) || (op == `OP_PARAM_SET);
  endfunction : has_data

  function automatic logic is_dout(input logic [7:0] op);
    is_dout = (op == `OP_ID_READ) || (op == `OP_STAT_RD) ||
              (op == `OP_STAT_UP_RD);
  endfunction : is_dout

  function automatic logic qpi_known(input logic [7:0] op);
    qpi_known = needs_wel(op) || is_read(op) || is_dout(op) ||
                (op == `OP_PAUSE) || (op == `OP_CONTINUE) ||
                (op == `OP_WRITE_ARM) || (op == `OP_WRITE_DISARM) ||
                (op == `OP_VOL_ARM) || (op == `OP_PARAM_SET) ||
                (op == `OP_QPI_EXIT) || (op == `OP_RST_ARM) ||
                (op == `OP_RST);
  endfunction : qpi_known

  function automatic logic [1:0] sec_area(input logic [23:0] a);
    logic hit;
    hit = (a[23:16] == `SEC_TOP_ZERO) && (a[11:9] == `SEC_MID_ZERO) &&
          (a[15:12] >= `SEC_AREA_FIRST) && (a[15:12] <= `SEC_AREA_LAST);
    sec_area = hit ? a[13:12] : 2'h0;
  endfunction : sec_area

  function automatic logic [23:0] wrap_next(input logic [23:0] a,
                                            input logic [1:0]  sel);
    logic [7:0] m;
    m = (`WRAP_BASE << sel) - 8'h01;
    wrap_next = {a[23:8], (a[7:0] & ~m) | ((a[7:0] + 8'h01) & m)};
  endfunction : wrap_next

  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  logic       sclk_s;
  logic       cs_n_s;
  logic [3:0] io_s;
  logic       sclk_p_q;
  logic       cs_p_q;

  pin_sync #(.WIDTH(6)) u_sync (
    .clk_i (SYS_CLK_I),
    .rst_i (SRST_I),
    .d_i   ({SCLK_I, CS_N_I, IO_I}),
    .q_o   ({sclk_s, cs_n_s, io_s})
  );

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      // Same level as the synchroniser's reset, so no false rise follows
      sclk_p_q <= 1'b1;
      cs_p_q   <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      cs_p_q   <= cs_n_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_p_q;
  wire sclk_fall = ~sclk_s & sclk_p_q;
  wire cs_fall   = ~cs_n_s & cs_p_q;
  wire cs_rise   = cs_n_s & ~cs_p_q;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  st_t         st_q, st_d;
  logic [7:0]  sh_q, sh_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  op_q, op_d;
  logic [23:0] addr_q, addr_d;
  logic [3:0]  dcnt_q, dcnt_d;
  logic [8:0]  nby_q, nby_d;
  logic        half_q, half_d;
  logic [3:0]  out_q, out_d;
  logic        oe_q, oe_d;
  logic [1:0]  idx_q, idx_d;
  logic [7:0]  d0_q, d0_d;
  logic [7:0]  d1_q, d1_d;
  logic        we;
  logic        wel_q;
  logic        vol_q;
  logic        rarm_q;
  logic        qpi_q;
  logic [7:0]  param_q;
  logic [7:0]  mem_rd;

  // IO3 carries the highest bit of each nibble
  wire [7:0] nib_byte  = {sh_q[3:0], io_s};
  wire [7:0] bit_byte  = {sh_q[6:0], io_s[0]};
  wire [7:0] opc_in    = qpi_q ? nib_byte : bit_byte;
  wire       opc_last  = qpi_q ? (cnt_q == `OPC_LAST_NIB)
                               : (cnt_q == `SPI_LAST_BIT);
  wire       opc_known = qpi_q ? qpi_known(opc_in)
                               : (opc_in == `OP_QPI_ENTER);
  wire       opc_stat  = (opc_in == `OP_STAT_WR) ||
                         (opc_in == `OP_STAT_UP_WR);
  // Refuse writing commands without the latch
  // Volatile arm admits only a status write
  wire       opc_ok    = opc_known & (~needs_wel(opc_in) | wel_q |
                                      (opc_stat & vol_q));

  wire [1:0] dsel      = param_q[`DUMMY_SEL_HI:`DUMMY_SEL_LO];
  wire [1:0] wsel      = param_q[`WRAP_SEL_HI:`WRAP_SEL_LO];
  // Dummy count from the read parameter byte
  wire [3:0] dummy_n   = (dsel == 2'h0) ? `DUMMY_SEL0 :
                         (dsel == 2'h1) ? `DUMMY_SEL1 :
                         (dsel == 2'h2) ? `DUMMY_SEL2 : `DUMMY_SEL3;
  // Byte limit for status and parameter writes
  wire [8:0] din_max   = (op_q == `OP_STAT_WR) ? `STAT_WR_MAX
                                               : `ONE_BYTE_MAX;

  // Maker byte then two device bytes, zero afterwards
  wire [7:0] id_byte   = (idx_q == 2'h0) ? MFR_ID :
                         (idx_q == 2'h1) ? DEV_ID[15:8] :
                         (idx_q == 2'h2) ? DEV_ID[7:0] : 8'h00;
  wire [7:0] stat_byte = 8'h00 | ({7'h00, wel_q} << `WEL_BIT);
  wire [7:0] src_byte  = (op_q == `OP_ID_READ)    ? id_byte :
                         (op_q == `OP_STAT_RD)    ? stat_byte :
                         (op_q == `OP_STAT_UP_RD) ? STAT_HI_O : mem_rd;
  wire [23:0] rd_next  = (op_q == `OP_WRAP_READ) ? wrap_next(addr_q, wsel)
                                                 : addr_q + 24'h000001;

  localparam logic [PAGE_AW-1:0] AW_ONE = {{(PAGE_AW-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    cnt_d  = cnt_q;
    op_d   = op_q;
    addr_d = addr_q;
    dcnt_d = dcnt_q;
    nby_d  = nby_q;
    half_d = half_q;
    out_d  = out_q;
    oe_d   = oe_q;
    idx_d  = idx_q;
    d0_d   = d0_q;
    d1_d   = d1_q;
    we     = 1'b0;
    case (st_q)
      ST_OPCODE: if (sclk_rise) begin
        sh_d  = opc_in;
        cnt_d = cnt_q + 4'h1;
        if (opc_last) begin
          op_d  = opc_in;
          cnt_d = 4'h0;
          idx_d = 2'h0;
          // Unknown or refused opcode waits for select
          if (!opc_ok) begin
            st_d = ST_IGNORE;
          end else if (has_addr(opc_in)) begin
            st_d = ST_ADDR;
          end else if (is_dout(opc_in)) begin
            st_d = ST_DOUT;
          end else if (has_data(opc_in)) begin
            st_d = ST_DIN;
          end else begin
            st_d = ST_WAIT;
          end
        end
      end
      ST_ADDR: if (sclk_rise) begin
        addr_d = {addr_q[19:0], io_s};
        cnt_d  = cnt_q + 4'h1;
        if (cnt_q == `ADDR_LAST_NIB) begin
          cnt_d  = 4'h0;
          dcnt_d = 4'h0;
          // Program goes straight to data, no dummy
          // Erase with address then waits for select
          if (is_read(op_q)) begin
            st_d = ST_DUMMY;
          end else if (has_data(op_q)) begin
            st_d = ST_DIN;
          end else begin
            st_d = ST_WAIT;
          end
        end
      end
      ST_DUMMY: if (sclk_rise) begin
        dcnt_d = dcnt_q + 4'h1;
        if (dcnt_q == dummy_n - 4'h1) begin
          st_d = ST_DOUT;
        end
      end
      ST_DIN: if (sclk_rise) begin
        sh_d  = nib_byte;
        cnt_d = {3'h0, ~cnt_q[0]};
        if (cnt_q[0]) begin
          nby_d = nby_q + 9'h001;
          if (is_prog(op_q)) begin
            // Data bytes fill the page, wrapping inside it
            we = 1'b1;
            addr_d[PAGE_AW-1:0] = addr_q[PAGE_AW-1:0] + AW_ONE;
          end else if (nby_q >= din_max) begin
            st_d = ST_IGNORE;
          end else if (nby_q == 9'h000) begin
            d0_d = nib_byte;
          end else begin
            d1_d = nib_byte;
          end
        end
      end
      // Output one nibble per falling edge on four lines
      // Upper nibble of each byte first
      ST_DOUT: if (sclk_fall) begin
        oe_d = 1'b1;
        if (!half_q) begin
          out_d  = src_byte[7:4];
          half_d = 1'b1;
        end else begin
          out_d  = src_byte[3:0];
          half_d = 1'b0;
          if (op_q == `OP_ID_READ) begin
            idx_d = (idx_q == `ID_LAST_IDX) ? idx_q : idx_q + 2'h1;
          end else begin
            addr_d = rd_next;
          end
        end
      end
      // Extra clocks void a no-argument command
      ST_WAIT: if (sclk_rise) begin
        st_d = ST_IGNORE;
      end
      ST_IDLE, ST_IGNORE: begin
        st_d = st_q;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (cs_fall) begin
      st_d   = ST_OPCODE;
      cnt_d  = 4'h0;
      nby_d  = 9'h000;
      half_d = 1'b0;
    end
    if (cs_rise) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      st_q   <= ST_IDLE;
      sh_q   <= 8'h00;
      cnt_q  <= 4'h0;
      op_q   <= 8'h00;
      addr_q <= 24'h000000;
      dcnt_q <= 4'h0;
      nby_q  <= 9'h000;
      half_q <= 1'b0;
      out_q  <= 4'h0;
      oe_q   <= 1'b0;
      idx_q  <= 2'h0;
      d0_q   <= 8'h00;
      d1_q   <= 8'h00;
    end else begin
      st_q   <= st_d;
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      op_q   <= op_d;
      addr_q <= addr_d;
      dcnt_q <= dcnt_d;
      nby_q  <= nby_d;
      half_q <= half_d;
      out_q  <= out_d;
      oe_q   <= oe_d;
      idx_q  <= idx_d;
      d0_q   <= d0_d;
      d1_q   <= d1_d;
    end
  end

  byte_store #(.AW(PAGE_AW)) u_store (
    .clk_i   (SYS_CLK_I),
    .rst_i   (SRST_I),
    .we_i    (we),
    .waddr_i (addr_q[PAGE_AW-1:0]),
    .wdata_i (nib_byte),
    .raddr_i (addr_q[PAGE_AW-1:0]),
    .rdata_o (mem_rd)
  );

  // ----------------------------------------------------------------------
  // Completion and control state
  // ----------------------------------------------------------------------
  // Completion needs a whole byte count; a half byte aborts
  wire din_done = (st_q == ST_DIN) & (cnt_q == 4'h0) & (nby_q != 9'h000);
  wire done     = cs_rise & ((st_q == ST_WAIT) | din_done);
  wire done_wr  = done & needs_wel(op_q);
  wire rst_done = done & (op_q == `OP_RST) & rarm_q;
  wire pause_ev = done & ((op_q == `OP_PAUSE) | (op_q == `OP_CONTINUE));

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      wel_q <= 1'b0;
    end else if (done_wr | rst_done | (done & ((op_q == `OP_WRITE_DISARM) |
                                              (op_q == `OP_VOL_ARM)))) begin
      wel_q <= 1'b0;
    // Arm sets the latch for one writing command
    end else if (done & (op_q == `OP_WRITE_ARM)) begin
      wel_q <= 1'b1;
    end
  end

  // Arms last only until the next select ends
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      vol_q  <= 1'b0;
      rarm_q <= 1'b0;
    end else if (cs_rise) begin
      // Only the next command sees the volatile arm
      vol_q  <= done & (op_q == `OP_VOL_ARM);
      rarm_q <= done & (op_q == `OP_RST_ARM);
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      qpi_q <= 1'b0;
    end else if (done & (op_q == `OP_QPI_EXIT)) begin
      qpi_q <= 1'b0;
    end else if (done & (op_q == `OP_QPI_ENTER)) begin
      qpi_q <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I | rst_done) begin
      param_q <= `PARAM_RST;
    end else if (done & (op_q == `OP_PARAM_SET)) begin
      param_q <= d0_q;
    end
  end

  // Writing commands, pause, continue and armed reset reported on completion
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      OP_VALID_O  <= 1'b0;
      OP_CODE_O   <= 8'h00;
      OP_ADDR_O   <= 24'h000000;
      OP_NBYTES_O <= 9'h000;
      SEC_AREA_O  <= 2'h0;
    end else begin
      OP_VALID_O <= done_wr | pause_ev | rst_done;
      if (done) begin
        OP_CODE_O   <= op_q;
        OP_ADDR_O   <= addr_q;
        OP_NBYTES_O <= nby_q;
        SEC_AREA_O  <= sec_area(addr_q);
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      STAT_LO_O       <= 8'h00;
      STAT_HI_O       <= 8'h00;
      STAT_HI_VALID_O <= 1'b0;
      STAT_VOLATILE_O <= 1'b0;
    end else if (done & (op_q == `OP_STAT_WR)) begin
      STAT_LO_O       <= d0_q;
      STAT_HI_O       <= (nby_q == `STAT_WR_MAX) ? d1_q : STAT_HI_O;
      STAT_HI_VALID_O <= (nby_q == `STAT_WR_MAX);
      STAT_VOLATILE_O <= vol_q;
    end else if (done & (op_q == `OP_STAT_UP_WR)) begin
      STAT_HI_O       <= d0_q;
      STAT_HI_VALID_O <= 1'b1;
      STAT_VOLATILE_O <= vol_q;
    end
  end

  assign IO_O         = out_q;
  assign IO_OE_O      = {4{oe_q}};
  assign WEL_O        = wel_q;
  assign QPI_MODE_O   = qpi_q;
  assign DUMMY_CLKS_O = dummy_n;
  assign WRAP_SEL_O   = wsel;
endmodule : qpi_command_write_latch

// ===== qpi_command_write_latch_checker.sv
// Port checks for the QPI command decoder
`timescale 1ns/10ps
module qpi_command_write_latch_checker (
  // Watched ports
  input wire logic        SYS_CLK_I,
  input wire logic        SRST_I,
  input wire logic        CS_N_I,
  input wire logic [3:0]  IO_OE_O,
  input wire logic        OP_VALID_O,
  input wire logic [7:0]  OP_CODE_O,
  input wire logic [23:0] OP_ADDR_O,
  input wire logic [1:0]  SEC_AREA_O,
  input wire logic        STAT_VOLATILE_O,
  input wire logic        WEL_O,
  input wire logic        QPI_MODE_O,
  input wire logic [3:0]  DUMMY_CLKS_O
);
  logic       wel_q;
  logic       armed_q;
  logic [2:0] cs_hi_q;
  wire        wr_op = OP_CODE_O inside {8'h01, 8'h31, 8'h02, 8'h32, 8'h20,
                        8'h52, 8'hd8, 8'h60, 8'hc7, 8'h42, 8'h44};
  // Rising latch arms one report, so a lingering level cannot re-arm
  always_ff @(posedge SYS_CLK_I) begin
    wel_q   <= WEL_O;
    armed_q <= !SRST_I && !OP_VALID_O && (armed_q || (WEL_O && !wel_q));
    cs_hi_q <= (SRST_I || !CS_N_I) ? 3'h0 : cs_hi_q + {2'h0, cs_hi_q != 3'h7};
  end
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);
  wel_reset_clear_a: assert property ($past(SRST_I) |-> !WEL_O
    && !QPI_MODE_O && DUMMY_CLKS_O == 4'ha) else $error("bad reset state");
  write_needs_arm_a: assert property (OP_VALID_O && wr_op |-> armed_q
    || (OP_CODE_O[3:0] == 4'h1 && STAT_VOLATILE_O)) else $error("unarmed op");
  write_clears_wel_a: assert property (OP_VALID_O && wr_op
    |-> ##[0:3] !WEL_O) else $error("latch kept after write");
  wel_set_idle_a: assert property ($rose(WEL_O) |-> $past(CS_N_I))
    else $error("latch set inside a frame");
  oe_cs_low_a: assert property (IO_OE_O != 4'h0 |-> cs_hi_q < 3'h6)
    else $error("output kept after select");
  oe_all_lines_a: assert property (IO_OE_O == 4'h0 ||
    (IO_OE_O == 4'hf && QPI_MODE_O)) else $error("partial output enable");
  dummy_legal_a: assert property (DUMMY_CLKS_O inside
    {4'ha, 4'h4, 4'h6, 4'h8}) else $error("illegal dummy count");
  sec_fields_a: assert property (OP_VALID_O && SEC_AREA_O != 2'h0 |->
    OP_ADDR_O[23:14] == 10'h0 && OP_ADDR_O[13:12] == SEC_AREA_O)
    else $error("security area mismatch");
endmodule : qpi_command_write_latch_checker
bind qpi_command_write_latch qpi_command_write_latch_checker chk (
  .SYS_CLK_I(SYS_CLK_I), .SRST_I(SRST_I), .CS_N_I(CS_N_I),
  .IO_OE_O(IO_OE_O), .OP_VALID_O(OP_VALID_O), .OP_CODE_O(OP_CODE_O),
  .OP_ADDR_O(OP_ADDR_O), .SEC_AREA_O(SEC_AREA_O),
  .STAT_VOLATILE_O(STAT_VOLATILE_O), .WEL_O(WEL_O),
  .QPI_MODE_O(QPI_MODE_O), .DUMMY_CLKS_O(DUMMY_CLKS_O));

// ===== qpi_host_model.sv
// Host flash controller model driving the QPI pins
`timescale 1ns/10ps
module qpi_host_model (
  // Flash pins
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic      [3:0] io_o,
  input  wire logic [3:0] io_i
);
  logic [63:0] rd;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o   = 4'h0;
  end
  // nibble set while clock low, taken at the rise
  task automatic beat(input logic [3:0] v);
    io_o = v;
    #40 sclk_o = 1'b1;
    rd = {rd[59:0], io_i};
    #40 sclk_o = 1'b0;
  endtask : beat
  // own select per command, opcode high nibble first
  task automatic frame(input logic [7:0] op, input int n,
                       input logic [63:0] t, input bit one);
    cs_n_o = 1'b0;
    #40;
    for (int i = one ? 7 : 1; i >= 0; i--)
      beat(one ? {3'h0, op[i]} : op[4*i +: 4]);
    for (int i = n - 1; i >= 0; i--)
      beat(t[4*i +: 4]);
    #40 cs_n_o = 1'b1;
    // Released lines must not keep showing the last nibble
    io_o = ~io_o;
    #160;
  endtask : frame
endmodule : qpi_host_model

// ===== qpi_command_write_latch_bench.sv
// Self-checking bench for the QPI command decoder
`timescale 1ns/10ps
module qpi_command_write_latch_bench;
  localparam logic [23:0] ID_EXP = 24'h3c7e21; // Arbitrary value
  logic        clk, rst;
  wire         sclk, csn, vld, write_enable_latch, qpi;
  wire  [3:0]  hio, dio, doe, dmy;
  wire  [7:0]  code, slo, shi;
  wire  [8:0]  nby;
  wire  [1:0]  wrp;
  wire  [23:0] addr;
  wire  [3:0]  pin = (doe & dio) | (~doe & hio);
  logic [31:0] r;
  logic [32:0] e;
  logic [32:0] notes[$];
  integer      seed;
  int          n_errors, samples_checked;
  logic [7:0]  ops[9] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h01, 8'h31,
                          8'h02, 8'h44};
  int          nib[9] = '{6, 6, 6, 0, 0, 4, 2, 8, 6};
  qpi_host_model host (.sclk_o(sclk), .cs_n_o(csn), .io_o(hio), .io_i(pin));
  qpi_command_write_latch #(.MFR_ID(ID_EXP[23:16]), .DEV_ID(ID_EXP[15:0]))
    uut (.SYS_CLK_I(clk), .SRST_I(rst), .SCLK_I(sclk), .CS_N_I(csn),
    .IO_I(pin), .IO_O(dio), .IO_OE_O(doe), .OP_VALID_O(vld),
    .OP_CODE_O(code), .OP_ADDR_O(addr), .OP_NBYTES_O(nby), .SEC_AREA_O(),
    .STAT_LO_O(slo), .STAT_HI_O(shi), .STAT_HI_VALID_O(), .STAT_VOLATILE_O(),
    .WEL_O(write_enable_latch), .QPI_MODE_O(qpi), .DUMMY_CLKS_O(dmy), .WRAP_SEL_O(wrp));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  // Commands expected to report leave a note before the frame goes out
  task automatic cmd(input logic [7:0] op, input int n, input logic [31:0] t,
                     input bit hit);
    if (hit)
      notes.push_back({n == 6, op, n == 6 ? t[23:0] : 24'h0});
    host.frame(op, n, {32'h0, t}, 1'b0);
  endtask : cmd
  // An unexpected report meets an unknown note and fails
  always @(posedge clk) begin
    if (vld === 1'b1) begin
      e = notes.size() > 0 ? notes.pop_front() : 'x;
      check({code, e[32] ? addr : 24'h0}, e[31:0]);
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    seed = 32'ha46947bd;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check({write_enable_latch, qpi, dmy}, {2'h0, 4'ha});
    host.frame(8'h38, 0, 64'h0, 1'b1);
    check(qpi, 1'b1);
    cmd(8'h20, 6, 32'h1000, 0);
    check(write_enable_latch, 1'b0);
    for (int k = 0; k < 9; k++) begin
      r = $random(seed);
      if (ops[k] == 8'h44)
        r[23:9] = 15'h0010;
      cmd(8'h06, 0, 0, 0);
      check(write_enable_latch, 1'b1);
      cmd(ops[k], nib[k], r, 1);
      check(write_enable_latch, 1'b0);
      if (ops[k] == 8'h01 || ops[k] == 8'h31)
        check({ops[k][5] ? r[15:8] : slo, shi}, r[15:0]);
    end
    cmd(8'h75, 0, 0, 1);
    cmd(8'h7a, 0, 0, 1);
    cmd(8'h06, 0, 0, 0);
    cmd(8'h13, 6, 32'h200000, 0);
    cmd(8'h99, 0, 0, 0);
    check(write_enable_latch, 1'b1);
    cmd(8'h66, 0, 0, 0);
    cmd(8'h99, 0, 0, 1);
    check(write_enable_latch, 1'b0);
    cmd(8'h06, 0, 0, 0);
    cmd(8'h04, 0, 0, 0);
    check(write_enable_latch, 1'b0);
    cmd(8'h52, 6, 0, 0);
    cmd(8'h06, 0, 0, 0);
    cmd(8'h50, 0, 0, 0);
    check(write_enable_latch, 1'b0);
    for (int k = 0; k < 4; k++) begin
      cmd(8'hc0, 2, k << 4, 0);
      check(dmy, (16'h864a >> (4 * k)) & 16'hf);
    end
    cmd(8'hc0, 2, 32'h11, 0);
    check({wrp, dmy}, 6'h14);
    cmd(8'h06, 0, 0, 0);
    cmd(8'h02, 8, 32'h105c, 1);
    check(nby, 9'h001);
    host.frame(8'h0c, 14, 64'h1f00000000, 1'b0);
    check(host.rd[7:0], 8'h5c);
    host.frame(8'h0b, 12, 64'h10000000, 1'b0);
    check(host.rd[7:0], 8'h5c);
    host.frame(8'heb, 12, 64'h10000000, 1'b0);
    check(host.rd[7:0], 8'h5c);
    cmd(8'h9f, 6, 0, 0);
    check(host.rd[23:0], ID_EXP);
    cmd(8'hff, 0, 0, 0);
    check(qpi, 1'b0);
    check(notes.size(), 0);
    print_verdict();
  end
endmodule : qpi_command_write_latch_bench
